// [rtl/vtif_pkg.sv]
// Package: constants and carrier types of the tag identity and frame-check block
package vtif_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_UID_LO = 8'h00;
  localparam logic [7:0] REG_UID_HI = 8'h04;
  localparam logic [7:0] REG_AFI = 8'h08;
  localparam logic [7:0] REG_DSFID = 8'h0c;
  localparam logic [7:0] REG_LOCK = 8'h10;
  localparam logic [7:0] REG_STAT = 8'h14;
  localparam logic [7:0] REG_IEN = 8'h18;
  localparam logic [7:0] REG_ICLR = 8'h1c;
  localparam logic [7:0] REG_CRC = 8'h20;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int LOCK_AFI_BIT = 0;
  localparam int LOCK_DSFID_BIT = 1;
  localparam int ST_FRAME_OK = 0;
  localparam int ST_CRC_ERR = 1;
  localparam int ST_AFI_MUTE = 2;
  localparam int ST_UID_REJ = 3;
  localparam int ST_LOCK_REJ = 4;
  localparam int NUM_EVT = 5;
  localparam logic [7:0] AFI_RESET = 8'h00;
  localparam logic [7:0] DSFID_RESET = 8'h00;
  localparam logic [3:0] AFI_ANY = 4'h0;

  // ----------------------------------------------------------------
  // Frame check sequence
  // ----------------------------------------------------------------
  localparam logic [15:0] CRC_PRESET = 16'hffff;
  localparam logic [15:0] CRC_POLY_REF = 16'h8408;
  localparam logic [15:0] CRC_RESIDUE = 16'hf0b8;

  // ----------------------------------------------------------------
  // Memory block geometry
  // ----------------------------------------------------------------
  localparam int BLK_BYTES = 32;
  localparam int UNIT_BYTES = 2;
  localparam int BLK_UNITS = BLK_BYTES / UNIT_BYTES;

  // ----------------------------------------------------------------
  // AXI4-Lite answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic afi_flag;
    logic [7:0] afi;
  } vtif_req_t;

  typedef struct packed {
    logic we;
    logic [4:0] idx;
    logic [7:0] data;
  } vtif_rfmem_t;

  typedef struct packed {
    logic we;
    logic [3:0] idx;
    logic [15:0] data;
  } vtif_spimem_t;

endpackage

// [rtl/vtif_blkmem.sv]
// Block buffer: one user block held as 16-bit words, registered read data
`timescale 1ns/1ps
module vtif_blkmem #(
  parameter int DW = 16,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // Clock
  input wire logic clk_in,
  // Access port
  input wire logic en_in,
  input wire logic we_in,
  input wire logic [DW/8-1:0] be_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [DW-1:0] wdata_in,
  output logic [DW-1:0] rdata_out
);

  // Byte lanes kept as separate arrays so the byte view can update one byte
  // without two processes writing the same memory
  for (genvar g = 0; g < DW/8; g++) begin : g_lane
    logic [7:0] lane_mem [DEPTH];
    always_ff @(posedge clk_in) begin
      if (en_in && we_in && be_in[g]) begin
        lane_mem[addr_in] <= wdata_in[8*g +: 8];
      end
      if (en_in) begin
        rdata_out[8*g +: 8] <= lane_mem[addr_in];
      end
    end
  end

endmodule

// [rtl/vtif_top.sv]
// Tag identity registers, family filter, frame check and block byte ordering
// Function
// - The radio side reaches a block as 32 bytes with byte 0 the least significant.
// - The serial side reaches the block in 2-byte units, most significant byte first.
// - The 64-bit identifier is allocation byte, maker byte, then a 48-bit serial.
// - The 48-bit serial is a product byte above a 40-bit individual number.
// - The identifier is read-only and every write to it is refused.
// - The 8-bit family identifier is writable and starts at zero.
// - The family identifier is two nibbles, a zero nibble matching everything.
// - With the family flag set a request is answered only on a family match.
// - Family and format identifiers are writable and each can be locked for good.
// - The 8-bit storage format identifier is writable and starts at zero.
// - A received frame is accepted only when its check sequence is valid.
// - Each sender appends a 2-byte check over all bytes before it.
// - The check register is preset to all ones at the start of each frame.
// - The check is sent low byte first, each byte least significant bit first.
// - Frame bytes go least significant bit first, multi-byte fields low byte first.
//
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module vtif_top #(
  parameter logic [7:0] ALLOC_CODE = 8'h5a,   // Arbitrary value
  parameter logic [7:0] MAKER_CODE = 8'h3c,   // Arbitrary value
  parameter logic [7:0] PRODUCT_CODE = 8'h11, // Arbitrary value
  parameter logic [39:0] SERIAL_NUM = 40'h0123456789
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Interrupt
  output logic irq_out,
  // Request family filter
  input wire logic req_valid_in,
  input wire vtif_pkg::vtif_req_t req_in,
  output logic resp_ok_out,
  output logic resp_mute_out,
  // Received frame bytes
  input wire logic rx_sof_in,
  input wire logic rx_byte_valid_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_eof_in,
  output logic frame_ok_out,
  output logic frame_bad_out,
  // Sent frame bytes
  input wire logic tx_sof_in,
  input wire logic tx_byte_valid_in,
  input wire logic [7:0] tx_byte_in,
  output logic [15:0] tx_fcs_out,
  // Radio side block access
  input wire logic rf_mem_valid_in,
  input wire vtif_pkg::vtif_rfmem_t rf_mem_in,
  output logic rf_rd_valid_out,
  output logic [7:0] rf_rdata_out,
  // Serial side block access
  input wire logic spi_mem_valid_in,
  input wire vtif_pkg::vtif_spimem_t spi_mem_in,
  output logic spi_grant_out,
  output logic spi_rd_valid_out,
  output logic [15:0] spi_rdata_out
);

  // ----------------------------------------------------------------
  // Identity and frame check state
  // ----------------------------------------------------------------
  logic [63:0] uid;
  logic [7:0] afi_q;
  logic [7:0] dsfid_q;
  logic [1:0] lock_q;
  logic [vtif_pkg::NUM_EVT-1:0] stat_q;
  logic [vtif_pkg::NUM_EVT-1:0] ien_q;
  logic [vtif_pkg::NUM_EVT-1:0] evt;
  logic [vtif_pkg::NUM_EVT-1:0] clr;
  logic [15:0] rx_crc_q;
  logic [15:0] tx_crc_q;
  logic fam_match;

  // bytes fold in low bit first
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ vtif_pkg::CRC_POLY_REF) : (r >> 1);
    end
    return r;
  endfunction

  // UID layout
  // allocation, maker, serial
  assign uid = {ALLOC_CODE, MAKER_CODE, PRODUCT_CODE, SERIAL_NUM};

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic aw_full_q;
  logic w_full_q;
  logic [7:0] wa_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  logic wr_go;
  logic wr_lo;
  logic wr_hit;
  logic [31:0] rd_mux;
  logic rd_hit;

  assign wr_go = aw_full_q && w_full_q && !s_axi_bvalid_out;
  assign wr_lo = wr_go && ws_q[0];

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      wa_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out <= 1'b1;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= vtif_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_full_q <= 1'b1;
        wa_q <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_full_q <= 1'b1;
        wd_q <= s_axi_wdata_in;
        ws_q <= s_axi_wstrb_in;
        s_axi_wready_out <= 1'b0;
      end
      if (wr_go) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= wr_hit ? vtif_pkg::RESP_OKAY : vtif_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out <= 1'b1;
      end
    end
  end

  always_comb begin
    case (wa_q)
      vtif_pkg::REG_UID_LO, vtif_pkg::REG_UID_HI, vtif_pkg::REG_AFI, vtif_pkg::REG_DSFID,
      vtif_pkg::REG_LOCK, vtif_pkg::REG_IEN, vtif_pkg::REG_ICLR: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr_in)
      vtif_pkg::REG_UID_LO: rd_mux = uid[31:0];
      vtif_pkg::REG_UID_HI: rd_mux = uid[63:32];
      vtif_pkg::REG_AFI: rd_mux = {24'h000000, afi_q};
      vtif_pkg::REG_DSFID: rd_mux = {24'h000000, dsfid_q};
      vtif_pkg::REG_LOCK: rd_mux = {30'h0000_0000, lock_q};
      vtif_pkg::REG_STAT: rd_mux = {27'h000_0000, stat_q};
      vtif_pkg::REG_IEN: rd_mux = {27'h000_0000, ien_q};
      vtif_pkg::REG_CRC: rd_mux = {tx_crc_q, rx_crc_q};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= vtif_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= rd_mux;
      s_axi_rresp_out <= rd_hit ? vtif_pkg::RESP_OKAY : vtif_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Identifier registers
  // ----------------------------------------------------------------
  // family identifier written unless locked
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      afi_q <= vtif_pkg::AFI_RESET;
      dsfid_q <= vtif_pkg::DSFID_RESET;
      lock_q <= 2'h0;
    end else if (wr_lo) begin
      if (wa_q == vtif_pkg::REG_AFI && !lock_q[vtif_pkg::LOCK_AFI_BIT]) begin
        afi_q <= wd_q[7:0];
      end
      if (wa_q == vtif_pkg::REG_DSFID && !lock_q[vtif_pkg::LOCK_DSFID_BIT]) begin
        dsfid_q <= wd_q[7:0];
      end
      if (wa_q == vtif_pkg::REG_LOCK) begin
        lock_q <= lock_q | wd_q[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Family filter
  // ----------------------------------------------------------------
  // zero nibble in the request matches any stored nibble
  assign fam_match = (req_in.afi[7:4] == vtif_pkg::AFI_ANY || req_in.afi[7:4] == afi_q[7:4])
                  && (req_in.afi[3:0] == vtif_pkg::AFI_ANY || req_in.afi[3:0] == afi_q[3:0]);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      resp_ok_out <= 1'b0;
      resp_mute_out <= 1'b0;
    end else begin
      resp_ok_out <= req_valid_in && (!req_in.afi_flag || fam_match);
      resp_mute_out <= req_valid_in && req_in.afi_flag && !fam_match;
    end
  end

  // ----------------------------------------------------------------
  // Frame check sequence
  // ----------------------------------------------------------------
  // preset on frame start
  // reflected polynomial over each byte, low bit first
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_crc_q <= vtif_pkg::CRC_PRESET;
    end else if (rx_sof_in) begin
      rx_crc_q <= vtif_pkg::CRC_PRESET;
    end else if (rx_byte_valid_in) begin
      rx_crc_q <= crc_byte(rx_crc_q, rx_byte_in);
    end
  end

  // Check bytes run through the register too, so a good frame leaves the fixed residue
  // accept only on the valid residue
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      frame_ok_out <= 1'b0;
      frame_bad_out <= 1'b0;
    end else begin
      frame_ok_out <= rx_eof_in && rx_crc_q == vtif_pkg::CRC_RESIDUE;
      frame_bad_out <= rx_eof_in && rx_crc_q != vtif_pkg::CRC_RESIDUE;
    end
  end

  // check over every sent byte after start
  // low byte of the sequence sits in bits 7:0 and goes first
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_crc_q <= vtif_pkg::CRC_PRESET;
      tx_fcs_out <= ~vtif_pkg::CRC_PRESET;
    end else if (tx_sof_in) begin
      tx_crc_q <= vtif_pkg::CRC_PRESET;
      tx_fcs_out <= ~vtif_pkg::CRC_PRESET;
    end else if (tx_byte_valid_in) begin
      tx_crc_q <= crc_byte(tx_crc_q, tx_byte_in);
      tx_fcs_out <= ~crc_byte(tx_crc_q, tx_byte_in);
    end
  end

  // ----------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------
  // identifier writes are refused and flagged
  assign evt[vtif_pkg::ST_UID_REJ] = wr_go &&
      (wa_q == vtif_pkg::REG_UID_LO || wa_q == vtif_pkg::REG_UID_HI);
  assign evt[vtif_pkg::ST_LOCK_REJ] = wr_lo &&
      ((wa_q == vtif_pkg::REG_AFI && lock_q[vtif_pkg::LOCK_AFI_BIT]) ||
       (wa_q == vtif_pkg::REG_DSFID && lock_q[vtif_pkg::LOCK_DSFID_BIT]));
  assign evt[vtif_pkg::ST_FRAME_OK] = frame_ok_out;
  assign evt[vtif_pkg::ST_CRC_ERR] = frame_bad_out;
  assign evt[vtif_pkg::ST_AFI_MUTE] = resp_mute_out;
  assign clr = (wr_lo && wa_q == vtif_pkg::REG_ICLR) ? wd_q[vtif_pkg::NUM_EVT-1:0] : '0;

  // A new event wins over a clear in the same cycle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stat_q <= '0;
      ien_q <= '0;
      irq_out <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~clr) | evt;
      if (wr_lo && wa_q == vtif_pkg::REG_IEN) begin
        ien_q <= wd_q[vtif_pkg::NUM_EVT-1:0];
      end
      irq_out <= |(((stat_q & ~clr) | evt) & ien_q);
    end
  end

  // ----------------------------------------------------------------
  // Block byte ordering
  // ----------------------------------------------------------------
  // Radio side has priority; serial side retries while not granted
  logic m_en;
  logic m_we;
  logic [1:0] m_be;
  logic [3:0] m_addr;
  logic [15:0] m_wdata;
  logic [15:0] m_rdata;
  logic rf_rd_q;
  logic rf_lane_q;
  logic spi_rd_q;

  // byte i sits at bits 8i+7:8i of the block, byte 0 least significant
  // serial unit k is bytes 2k+1 and 2k with the higher byte on top
  always_comb begin
    m_en = rf_mem_valid_in || spi_mem_valid_in;
    if (rf_mem_valid_in) begin
      m_we = rf_mem_in.we;
      m_addr = rf_mem_in.idx[4:1];
      m_be = rf_mem_in.idx[0] ? 2'h2 : 2'h1;
      m_wdata = {rf_mem_in.data, rf_mem_in.data};
    end else begin
      m_we = spi_mem_in.we;
      m_addr = spi_mem_in.idx;
      m_be = 2'h3;
      m_wdata = spi_mem_in.data;
    end
  end

  vtif_blkmem #(
    .DW(16),
    .DEPTH(vtif_pkg::BLK_UNITS),
    .AW(4)
  ) u_blkmem (
    .clk_in(clk_in),
    .en_in(m_en),
    .we_in(m_we),
    .be_in(m_be),
    .addr_in(m_addr),
    .wdata_in(m_wdata),
    .rdata_out(m_rdata)
  );

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rf_rd_q <= 1'b0;
      rf_lane_q <= 1'b0;
      spi_rd_q <= 1'b0;
      spi_grant_out <= 1'b0;
      rf_rd_valid_out <= 1'b0;
      rf_rdata_out <= 8'h00;
      spi_rd_valid_out <= 1'b0;
      spi_rdata_out <= 16'h0000;
    end else begin
      rf_rd_q <= rf_mem_valid_in && !rf_mem_in.we;
      rf_lane_q <= rf_mem_in.idx[0];
      spi_rd_q <= spi_mem_valid_in && !rf_mem_valid_in && !spi_mem_in.we;
      spi_grant_out <= spi_mem_valid_in && !rf_mem_valid_in;
      rf_rd_valid_out <= rf_rd_q;
      spi_rd_valid_out <= spi_rd_q;
      if (rf_rd_q) begin
        rf_rdata_out <= rf_lane_q ? m_rdata[15:8] : m_rdata[7:0];
      end
      if (spi_rd_q) begin
        spi_rdata_out <= m_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_wr_to(logic [7:0] a);
    wr_lo && wa_q == a;
  endsequence

  property p_uid_ro;
    evt[vtif_pkg::ST_UID_REJ] |=> stat_q[vtif_pkg::ST_UID_REJ] && s_axi_bvalid_out;
  endproperty
  a_uid_ro: assert property (p_uid_ro) else $error("uid write not flagged");

  property p_uid_hi;
    s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in == vtif_pkg::REG_UID_HI
      |=> s_axi_rdata_out == {ALLOC_CODE, MAKER_CODE, PRODUCT_CODE, SERIAL_NUM[39:32]};
  endproperty
  a_uid_hi: assert property (p_uid_hi) else $error("uid upper word wrong");

  property p_afi_lock;
    s_wr_to(vtif_pkg::REG_AFI) and lock_q[vtif_pkg::LOCK_AFI_BIT]
      |=> $stable(afi_q) ##1 stat_q[vtif_pkg::ST_LOCK_REJ];
  endproperty
  a_afi_lock: assert property (p_afi_lock) else $error("locked afi changed");

  property p_dsfid_wr;
    s_wr_to(vtif_pkg::REG_DSFID) and !lock_q[vtif_pkg::LOCK_DSFID_BIT]
      |=> dsfid_q == $past(wd_q[7:0]);
  endproperty
  a_dsfid_wr: assert property (p_dsfid_wr) else $error("dsfid not written");

  property p_afi_mute;
    req_valid_in && req_in.afi_flag && req_in.afi[7:4] != vtif_pkg::AFI_ANY
      && req_in.afi[7:4] != afi_q[7:4] |=> !resp_ok_out && resp_mute_out;
  endproperty
  a_afi_mute: assert property (p_afi_mute) else $error("answered on mismatch");

  property p_rx_preset;
    rx_sof_in |=> rx_crc_q == vtif_pkg::CRC_PRESET;
  endproperty
  a_rx_preset: assert property (p_rx_preset) else $error("rx check not preset");

  property p_rx_bad;
    rx_eof_in && rx_crc_q != vtif_pkg::CRC_RESIDUE |=> frame_bad_out && !frame_ok_out
      ##1 stat_q[vtif_pkg::ST_CRC_ERR];
  endproperty
  a_rx_bad: assert property (p_rx_bad) else $error("bad frame accepted");

  property p_tx_inv;
    tx_byte_valid_in && !tx_sof_in |=> tx_fcs_out == ~tx_crc_q;
  endproperty
  a_tx_inv: assert property (p_tx_inv) else $error("sent check not inverted");

  property p_rf_lane;
    rf_mem_valid_in && !rf_mem_in.we ##1 1'b1 |=> rf_rd_valid_out;
  endproperty
  a_rf_lane: assert property (p_rf_lane) else $error("radio read lost");

endmodule

// [test/vtif_rdr_model.sv]
// Reader model: sends request frames with appended check bytes
`timescale 1ns/1ps
module vtif_rdr_model (
  // Clock
  input wire logic clk_in,
  // Frame byte stream
  output logic sof_out,
  output logic byte_valid_out,
  output logic [7:0] byte_out,
  output logic eof_out
);
  initial begin
    sof_out = 1'h0;
    byte_valid_out = 1'h0;
    byte_out = 8'h00;
    eof_out = 1'h0;
  end

  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ vtif_pkg::CRC_POLY_REF) : (r >> 1);
    end
    return r;
  endfunction

  // A set bad flag corrupts one check bit on purpose
  task automatic send(input logic [7:0] pl[$], input logic bad);
    logic [15:0] c;
    logic [7:0] q[$];
    c = vtif_pkg::CRC_PRESET;
    q = pl;
    foreach (pl[i]) c = crc_upd(c, pl[i]);
    c = ~c ^ {15'h0000, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    sof_out <= 1'h1;
    @(posedge clk_in);
    sof_out <= 1'h0;
    foreach (q[i]) begin
      byte_valid_out <= 1'h1;
      byte_out <= q[i];
      @(posedge clk_in);
    end
    // Released line shows the inverse so a stale byte cannot pass
    byte_valid_out <= 1'h0;
    byte_out <= ~q[q.size()-1];
    eof_out <= 1'h1;
    @(posedge clk_in);
    eof_out <= 1'h0;
  endtask
endmodule

// [test/tb_vtif_top.sv]
// Self-checking bench of the tag identity and frame-check block
`timescale 1ns/1ps
module tb_vtif_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [7:0] ALLOC = 8'ha7; // Arbitrary value
  localparam logic [7:0] MAKER = 8'h42; // Arbitrary value
  localparam logic [7:0] PROD = 8'h69; // Arbitrary value
  localparam logic [39:0] SER = 40'h1122334455;
  localparam logic [1:0] OK = vtif_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = vtif_pkg::RESP_SLVERR;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] awa = 8'h00, ara = 8'h00, txb = 8'h00;
  logic [31:0] wd = 32'h0;
  logic awv = 1'h0, wv = 1'h0, bre = 1'h0, arv = 1'h0, rre = 1'h0;
  logic rqv = 1'h0, txs = 1'h0, txv = 1'h0, rfv = 1'h0, spv = 1'h0;
  vtif_pkg::vtif_req_t rq = '0;
  vtif_pkg::vtif_rfmem_t rf = '0;
  vtif_pkg::vtif_spimem_t sp = '0;
  logic awr, wrd, bv, arr, rv, irq, rok, rmu, fok, fbad, rfrv, sg, srv, gnt;
  logic rxs, rxv, rxe;
  logic [1:0] br, rr;
  logic [31:0] rd;
  logic [15:0] fcs, srd;
  logic [7:0] rfrd, rxb;
  logic [8:0] rfo;
  logic [16:0] spo;
  int error_cnt = 0;
  int n_compared = 0;

  always #10 clk = ~clk;

  vtif_top #(.ALLOC_CODE(ALLOC), .MAKER_CODE(MAKER), .PRODUCT_CODE(PROD), .SERIAL_NUM(SER)) dut (
    .clk_in(clk), .rst_n_in(rst_n),
    .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd),
    .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(bre),
    .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rd), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rre),
    .irq_out(irq), .req_valid_in(rqv), .req_in(rq), .resp_ok_out(rok), .resp_mute_out(rmu),
    .rx_sof_in(rxs), .rx_byte_valid_in(rxv), .rx_byte_in(rxb), .rx_eof_in(rxe),
    .frame_ok_out(fok), .frame_bad_out(fbad), .tx_sof_in(txs), .tx_byte_valid_in(txv),
    .tx_byte_in(txb), .tx_fcs_out(fcs), .rf_mem_valid_in(rfv), .rf_mem_in(rf),
    .rf_rd_valid_out(rfrv), .rf_rdata_out(rfrd), .spi_mem_valid_in(spv), .spi_mem_in(sp),
    .spi_grant_out(sg), .spi_rd_valid_out(srv), .spi_rdata_out(srd));

  vtif_rdr_model rdr (.clk_in(clk), .sof_out(rxs), .byte_valid_out(rxv), .byte_out(rxb),
    .eof_out(rxe));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Waits are bounded; a missing answer ends the run
  task automatic wc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    n = 0;
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    bre <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (awv && awr) awv <= 1'h0;
      if (wv && wrd) wv <= 1'h0;
    end while (bv !== 1'h1 && n < 100);
    if (n >= 100) begin
      chk("write answer", 32'h1, 32'h0);
      give_verdict();
    end
    chk($sformatf("wresp %h", a), {30'h0, e}, {30'h0, br});
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    ara <= a;
    arv <= 1'h1;
    rre <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (arv && arr) arv <= 1'h0;
    end while (rv !== 1'h1 && n < 100);
    if (n >= 100) begin
      chk("read answer", 32'h1, 32'h0);
      give_verdict();
    end
    chk($sformatf("rdata %h", a), e, rd);
    chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, rr});
  endtask

  task automatic fl(input logic f, input logic [7:0] a, input logic ok);
    rqv <= 1'h1;
    rq <= {f, a};
    @(posedge clk);
    rqv <= 1'h0;
    @(posedge clk);
    chk($sformatf("answer %h %h", f, a), {30'h0, ok, !ok}, {30'h0, rok, rmu});
  endtask

  task automatic acc(input logic rv_i, input logic [13:0] r, input logic sv_i,
    input logic [20:0] s);
    rfv <= rv_i;
    rf <= r;
    spv <= sv_i;
    sp <= s;
    @(posedge clk);
    rfv <= 1'h0;
    spv <= 1'h0;
    @(posedge clk);
    gnt = sg;
    @(posedge clk);
    rfo = {rfrv, rfrd};
    spo = {srv, srd};
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] mb[$];
    logic [15:0] c;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    rc(vtif_pkg::REG_UID_LO, SER[31:0], OK);
    rc(vtif_pkg::REG_UID_HI, {ALLOC, MAKER, PROD, SER[39:32]}, OK);
    rc(vtif_pkg::REG_AFI, 32'h0, OK);
    rc(vtif_pkg::REG_DSFID, 32'h0, OK);
    rc(8'h24, 32'h0, ERR);
    wc(vtif_pkg::REG_UID_LO, 32'h0, OK);
    rc(vtif_pkg::REG_UID_LO, SER[31:0], OK);
    rc(vtif_pkg::REG_STAT, 32'h8, OK);
    wc(vtif_pkg::REG_STAT, 32'h0, ERR);
    wc(vtif_pkg::REG_ICLR, 32'h1f, OK);
    $display("test identity done");
    wc(vtif_pkg::REG_AFI, 32'h35, OK);
    wc(vtif_pkg::REG_DSFID, 32'h9c, OK);
    fl(1'h0, 8'h77, 1'h1);
    fl(1'h1, 8'h00, 1'h1);
    fl(1'h1, 8'h30, 1'h1);
    fl(1'h1, 8'h05, 1'h1);
    fl(1'h1, 8'h35, 1'h1);
    fl(1'h1, 8'h36, 1'h0);
    fl(1'h1, 8'h40, 1'h0);
    rc(vtif_pkg::REG_STAT, 32'h4, OK);
    $display("test family done");
    wc(vtif_pkg::REG_ICLR, 32'h1f, OK);
    wc(vtif_pkg::REG_IEN, 32'h10, OK);
    wc(vtif_pkg::REG_LOCK, 32'h3, OK);
    wc(vtif_pkg::REG_AFI, 32'h12, OK);
    wc(vtif_pkg::REG_DSFID, 32'h12, OK);
    rc(vtif_pkg::REG_AFI, 32'h35, OK);
    rc(vtif_pkg::REG_DSFID, 32'h9c, OK);
    chk("irq raised", 32'h1, {31'h0, irq});
    wc(vtif_pkg::REG_ICLR, 32'h10, OK);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wc(vtif_pkg::REG_IEN, 32'h0, OK);
    wc(vtif_pkg::REG_AFI, 32'h12, OK);
    rc(vtif_pkg::REG_STAT, 32'h10, OK);
    chk("irq masked", 32'h0, {31'h0, irq});
    $display("test lock done");
    mb = '{8'h26, 8'h01, 8'h00};
    for (int i = 0; i < 3; i++) begin
      rdr.send(mb, i == 1);
      @(posedge clk);
      chk("frame", {30'h0, i != 1, i == 1}, {30'h0, fok, fbad});
    end
    txs <= 1'h1;
    @(posedge clk);
    txs <= 1'h0;
    c = vtif_pkg::CRC_PRESET;
    foreach (mb[i]) begin
      txv <= 1'h1;
      txb <= mb[i];
      c = rdr.crc_upd(c, mb[i]);
      @(posedge clk);
    end
    txv <= 1'h0;
    @(posedge clk);
    chk("tx check", {16'h0, ~c}, {16'h0, fcs});
    $display("test frames done");
    for (int i = 0; i < 32; i++) acc(1'h1, {1'h1, 5'(i), 8'(i * 37 + 5)}, 1'h0, '0);
    for (int i = 0; i < 16; i++) begin
      acc(1'h0, '0, 1'h1, {1'h0, 4'(i), 16'h0});
      chk("unit", {16'h3, 8'(i * 74 + 42), 8'(i * 74 + 5)}, {14'h0, gnt, spo});
    end
    acc(1'h0, '0, 1'h1, {1'h1, 4'h3, 16'habcd});
    acc(1'h1, {1'h0, 5'h06, 8'h00}, 1'h1, {1'h1, 4'h3, 16'h0});
    chk("byte 6", {24'h1, 8'hcd}, {22'h0, gnt, rfo});
    acc(1'h1, {1'h0, 5'h07, 8'h00}, 1'h0, '0);
    chk("byte 7", {24'h1, 8'hab}, {23'h0, rfo});
    $display("test memory done");
    give_verdict();
  end
endmodule
